// ---- hw/i2ctg_map.svh ----
// Register indexes, field positions, reset values of the two-wire bus timing generator
`ifndef I2CTG_MAP_SVH
`define I2CTG_MAP_SVH

// ==========================================================================
// Register indexes on the register port
`define I2CTG_IDX_DIV 3'h0
`define I2CTG_IDX_START 3'h1
`define I2CTG_IDX_STOP 3'h2
`define I2CTG_IDX_DATA 3'h3
`define I2CTG_IDX_CLK 3'h4
`define I2CTG_IDX_STAT 3'h5

// ==========================================================================
// Field positions: every timing register holds two 16-bit counts
`define I2CTG_LO_LSB 0
`define I2CTG_HI_LSB 16
`define I2CTG_STAT_IDLE_BIT 0
`define I2CTG_STAT_BUSY_BIT 1
`define I2CTG_STAT_BOOT_BIT 2

// ==========================================================================
// Reset values of the timing counts
`define I2CTG_RST_MICRO_DIV 16'h0063
`define I2CTG_RST_MILLI_DIV 16'h03e7
`define I2CTG_RST_START_SU 16'h01d7
`define I2CTG_RST_START_HD 16'h0191
`define I2CTG_RST_STOP_SU 16'h0191
`define I2CTG_RST_IDLE_CNT 16'h0033
`define I2CTG_RST_SDA_SU 16'h007e
`define I2CTG_RST_SDA_HD 16'h001f
`define I2CTG_RST_SCL_HI 16'h01f4
`define I2CTG_RST_SCL_LO 16'h01f4

`endif

// ---- hw/i2ctg_pkg.sv ----
// Types shared by the two-wire bus timing generator
package i2ctg_pkg;

  // ==========================================================================
  // Timing set used by the bus sequencer and the prescaler
  typedef struct packed {
    logic [15:0] micro_div;
    logic [15:0] milli_div;
    logic [15:0] start_su;
    logic [15:0] start_hd;
    logic [15:0] stop_su;
    logic [15:0] idle_cnt;
    logic [15:0] sda_su;
    logic [15:0] sda_hd;
    logic [15:0] scl_hi;
    logic [15:0] scl_lo;
  } i2ctg_timing_s;

  // ==========================================================================
  // Master commands
  typedef enum logic [1:0] {
    OP_START = 2'h1,
    OP_BIT = 2'h2,
    OP_STOP = 2'h3
  } i2ctg_op_e;

  // ==========================================================================
  // Master bus sequencer states
  typedef enum logic [9:0] {
    ST_IDLE = 10'h001,
    ST_WAIT_IDLE = 10'h002,
    ST_START_SU = 10'h004,
    ST_START_HD = 10'h008,
    ST_HELD = 10'h010,
    ST_BIT_HOLD = 10'h020,
    ST_BIT_LOW = 10'h040,
    ST_BIT_HIGH = 10'h080,
    ST_STOP_SU = 10'h100,
    ST_STOP_POST = 10'h200
  } i2ctg_state_e;

  // Slave data-drive states
  typedef enum logic [2:0] {
    SL_IDLE = 3'h1,
    SL_HOLD = 3'h2,
    SL_SETUP = 3'h4
  } i2ctg_slv_e;

endpackage

// ---- hw/i2ctg_timer.sv ----
// Loadable down counter used for every timed phase
module i2ctg_timer #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Control
  input wire logic load,
  input wire logic [W-1:0] value,
  input wire logic en,
  // Status
  output logic done
);

  if (W < 2) begin : g_chk
    $error("i2ctg_timer: width too small");
  end

  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;

  always_comb begin
    next_cnt = cnt;
    if (load) begin
      next_cnt = value;
    end else if (en && cnt != '0) begin
      next_cnt = cnt - 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      cnt <= '1;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign done = (cnt == '0);

endmodule

// ---- hw/i2ctg_top.sv ----
// Two-wire bus timing generator: prescaler, shadowed timing set, master and slave bus timing
//
// What this block does
// - Micro tick every micro divider plus one clocks
// - Milli tick every milli divider plus one micros
// - Both lines high start-setup cycles before start
// - Start-setup count also times hold after stop
// - Data low start-hold cycles before clock low
// - Stop-setup cycles clock high, data low first
// - After reset, clock high idle-count micros means idle
// - Master waits both lines high idle-count micros
// - Idle count zero means bus idle immediately
// - Data set data-setup cycles before clock rises
// - Data held data-hold cycles after clock falls
// - Master clock high for clock-high count cycles
// - Master clock low for clock-low count, stretchable
// - Boot load uses frozen shadow timing copies
// - Rewritten timings take effect after boot completes
// - Bus phase periods counted in reference clock cycles, idle count in micros
`include "i2ctg_map.svh"

module i2ctg_top #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Register port
  input wire logic REG_WR_EN,
  input wire logic REG_RD_EN,
  input wire logic [2:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  output logic [31:0] REG_RDATA,
  // Boot loader status
  input wire logic BOOT_ACTIVE,
  // Master command port
  input wire logic CMD_VALID,
  input wire i2ctg_pkg::i2ctg_op_e CMD_OP,
  input wire logic CMD_BIT,
  output logic CMD_READY,
  output logic RX_VALID,
  output logic RX_BIT,
  output logic BUSY,
  output logic BUS_IDLE,
  // Slave data port
  input wire logic SLV_ACTIVE,
  input wire logic SLV_BIT,
  // Ticks for the timeout timers
  output logic MICRO_TICK,
  output logic MILLI_TICK,
  // Bus pins, open drain: output enable high pulls the line low
  input wire logic SCL_I,
  output logic SCL_O,
  output logic SCL_OE,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE
);
  import i2ctg_pkg::*;

  if (CNT_W != 16) begin : g_chk
    $error("i2ctg_top: timing fields are 16 bits wide");
  end

  localparam i2ctg_timing_s RST_TIMING = '{
    micro_div: `I2CTG_RST_MICRO_DIV, milli_div: `I2CTG_RST_MILLI_DIV,
    start_su: `I2CTG_RST_START_SU, start_hd: `I2CTG_RST_START_HD,
    stop_su: `I2CTG_RST_STOP_SU, idle_cnt: `I2CTG_RST_IDLE_CNT,
    sda_su: `I2CTG_RST_SDA_SU, sda_hd: `I2CTG_RST_SDA_HD,
    scl_hi: `I2CTG_RST_SCL_HI, scl_lo: `I2CTG_RST_SCL_LO};

  // ==========================================================================
  // Register file and shadow copy
  logic [31:0] regs [0:4];
  logic [31:0] next_regs [0:4];
  logic [31:0] next_rdata;
  i2ctg_timing_s live;
  i2ctg_timing_s cur;
  i2ctg_timing_s next_cur;
  i2ctg_state_e state;
  logic bus_idle;

  always_comb begin
    for (int i = 0; i < 5; i++) begin
      next_regs[i] = regs[i];
    end
    if (REG_WR_EN && REG_ADDR <= `I2CTG_IDX_CLK) begin
      next_regs[REG_ADDR] = REG_WDATA;
    end
    next_rdata = REG_RDATA;
    if (REG_RD_EN) begin
      if (REG_ADDR <= `I2CTG_IDX_CLK) begin
        next_rdata = regs[REG_ADDR];
      end else if (REG_ADDR == `I2CTG_IDX_STAT) begin
        next_rdata = '0;
        next_rdata[`I2CTG_STAT_IDLE_BIT] = bus_idle;
        next_rdata[`I2CTG_STAT_BUSY_BIT] = (state != ST_IDLE);
        next_rdata[`I2CTG_STAT_BOOT_BIT] = BOOT_ACTIVE;
      end else begin
        next_rdata = '0;
      end
    end
  end

  assign live.micro_div = regs[`I2CTG_IDX_DIV][`I2CTG_LO_LSB +: 16];
  assign live.milli_div = regs[`I2CTG_IDX_DIV][`I2CTG_HI_LSB +: 16];
  assign live.start_su = regs[`I2CTG_IDX_START][`I2CTG_LO_LSB +: 16];
  assign live.start_hd = regs[`I2CTG_IDX_START][`I2CTG_HI_LSB +: 16];
  assign live.stop_su = regs[`I2CTG_IDX_STOP][`I2CTG_LO_LSB +: 16];
  assign live.idle_cnt = regs[`I2CTG_IDX_STOP][`I2CTG_HI_LSB +: 16];
  assign live.sda_su = regs[`I2CTG_IDX_DATA][`I2CTG_LO_LSB +: 16];
  assign live.sda_hd = regs[`I2CTG_IDX_DATA][`I2CTG_HI_LSB +: 16];
  assign live.scl_hi = regs[`I2CTG_IDX_CLK][`I2CTG_LO_LSB +: 16];
  assign live.scl_lo = regs[`I2CTG_IDX_CLK][`I2CTG_HI_LSB +: 16];

  // Freeze the working set while the boot loader reads the EEPROM, so a chain
  // setup written mid-load only lands once the load is over
  always_comb begin
    next_cur = BOOT_ACTIVE ? cur : live;
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      regs[`I2CTG_IDX_DIV] <= {`I2CTG_RST_MILLI_DIV, `I2CTG_RST_MICRO_DIV};
      regs[`I2CTG_IDX_START] <= {`I2CTG_RST_START_HD, `I2CTG_RST_START_SU};
      regs[`I2CTG_IDX_STOP] <= {`I2CTG_RST_IDLE_CNT, `I2CTG_RST_STOP_SU};
      regs[`I2CTG_IDX_DATA] <= {`I2CTG_RST_SDA_HD, `I2CTG_RST_SDA_SU};
      regs[`I2CTG_IDX_CLK] <= {`I2CTG_RST_SCL_LO, `I2CTG_RST_SCL_HI};
      REG_RDATA <= '0;
      cur <= RST_TIMING;
    end else begin
      for (int i = 0; i < 5; i++) begin
        regs[i] <= next_regs[i];
      end
      REG_RDATA <= next_rdata;
      cur <= next_cur;
    end
  end

  // ==========================================================================
  // Prescaler: micros counted in reference clocks, millis counted in micros
  logic [15:0] us_cnt;
  logic [15:0] next_us_cnt;
  logic [15:0] ms_cnt;
  logic [15:0] next_ms_cnt;
  logic micro_tick;
  logic milli_tick;

  always_comb begin
    // >= rather than == so a shrunken divider cannot strand the counter
    micro_tick = (us_cnt >= cur.micro_div);
    next_us_cnt = micro_tick ? 16'h0000 : us_cnt + 16'h0001;
    milli_tick = micro_tick && (ms_cnt >= cur.milli_div);
    next_ms_cnt = ms_cnt;
    if (micro_tick) begin
      next_ms_cnt = milli_tick ? 16'h0000 : ms_cnt + 16'h0001;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      us_cnt <= '0;
      ms_cnt <= '0;
      MICRO_TICK <= 1'b0;
      MILLI_TICK <= 1'b0;
    end else begin
      us_cnt <= next_us_cnt;
      ms_cnt <= next_ms_cnt;
      MICRO_TICK <= micro_tick;
      MILLI_TICK <= milli_tick;
    end
  end

  // ==========================================================================
  // Idle detect, counted in micro ticks
  logic idle_armed;
  logic idle_load;
  logic idle_done;
  logic next_bus_idle;
  i2ctg_state_e next_state;

  always_comb begin
    // After reset only the clock is watched; before a master start both lines
    if (next_state == ST_WAIT_IDLE && state != ST_WAIT_IDLE) begin
      idle_load = 1'b1;
    end else if (state == ST_WAIT_IDLE) begin
      idle_load = !(SCL_I && SDA_I);
    end else begin
      idle_load = !SCL_I || !idle_armed;
    end
    next_bus_idle = bus_idle || (idle_armed && idle_done && SCL_I);
  end

  i2ctg_timer #(.W(16)) u_idle_tmr (
    .CLK(CLK),
    .SYS_RST(SYS_RST),
    .load(idle_load),
    .value(cur.idle_cnt),
    .en(micro_tick),
    .done(idle_done)
  );

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      idle_armed <= 1'b0;
      bus_idle <= 1'b0;
    end else begin
      idle_armed <= 1'b1;
      bus_idle <= next_bus_idle;
    end
  end

  // ==========================================================================
  // Master bus sequencer
  logic scl_drv;
  logic next_scl_drv;
  logic sda_drv;
  logic next_sda_drv;
  logic hi_seen;
  logic next_hi_seen;
  logic is_stop;
  logic next_is_stop;
  logic tx_bit;
  logic next_tx_bit;
  logic next_rx_bit;
  logic next_rx_valid;
  logic ph_hold;
  logic ph_load;
  logic ph_done;
  logic [15:0] ph_val;
  logic [15:0] low_rem;

  always_comb begin
    next_state = state;
    next_scl_drv = scl_drv;
    next_sda_drv = sda_drv;
    next_hi_seen = hi_seen;
    next_is_stop = is_stop;
    next_tx_bit = tx_bit;
    next_rx_bit = RX_BIT;
    next_rx_valid = 1'b0;
    ph_hold = 1'b0;
    case (state)
      ST_IDLE: begin
        if (CMD_VALID && CMD_OP == OP_START) begin
          next_state = ST_WAIT_IDLE;
        end
      end
      ST_WAIT_IDLE: begin
        if (idle_done && SCL_I && SDA_I) begin
          next_state = ST_START_SU;
        end
      end
      ST_START_SU: begin
        ph_hold = !(SCL_I && SDA_I);
        if (ph_done && !ph_hold) begin
          next_sda_drv = 1'b1;
          next_state = ST_START_HD;
        end
      end
      ST_START_HD: begin
        ph_hold = SDA_I;
        if (ph_done && !ph_hold) begin
          next_scl_drv = 1'b1;
          next_state = ST_HELD;
        end
      end
      ST_HELD: begin
        if (CMD_VALID && CMD_OP == OP_BIT) begin
          next_tx_bit = CMD_BIT;
          next_is_stop = 1'b0;
          next_state = ST_BIT_HOLD;
        end else if (CMD_VALID && CMD_OP == OP_STOP) begin
          next_tx_bit = 1'b0;
          next_is_stop = 1'b1;
          next_state = ST_BIT_HOLD;
        end
      end
      ST_BIT_HOLD: begin
        if (ph_done) begin
          next_sda_drv = !tx_bit;
          next_state = ST_BIT_LOW;
        end
      end
      ST_BIT_LOW: begin
        if (ph_done) begin
          next_scl_drv = 1'b0;
          next_hi_seen = 1'b0;
          next_state = is_stop ? ST_STOP_SU : ST_BIT_HIGH;
        end
      end
      ST_BIT_HIGH: begin
        // The high time starts when the line is seen high; a slave stretching
        // the clock therefore lengthens the low time, not the high one
        ph_hold = !SCL_I && !hi_seen;
        if (SCL_I) begin
          next_hi_seen = 1'b1;
        end
        if (hi_seen && (ph_done || !SCL_I)) begin
          next_rx_bit = SDA_I;
          next_rx_valid = 1'b1;
          next_scl_drv = 1'b1;
          next_state = ST_HELD;
        end
      end
      ST_STOP_SU: begin
        ph_hold = !SCL_I || SDA_I;
        if (ph_done && !ph_hold) begin
          next_sda_drv = 1'b0;
          next_state = ST_STOP_POST;
        end
      end
      ST_STOP_POST: begin
        if (ph_done) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Phase count is chosen for the phase being entered and reloaded while the
  // lines are not yet where the phase wants them
  always_comb begin
    low_rem = (cur.scl_lo > cur.sda_hd) ? cur.scl_lo - cur.sda_hd : 16'h0000;
    ph_load = (next_state != state) || ph_hold;
    case (next_state)
      ST_START_SU: ph_val = cur.start_su;
      ST_START_HD: ph_val = cur.start_hd;
      ST_BIT_HOLD: ph_val = cur.sda_hd;
      ST_BIT_LOW: ph_val = (low_rem > cur.sda_su) ? low_rem : cur.sda_su;
      ST_BIT_HIGH: ph_val = cur.scl_hi;
      ST_STOP_SU: ph_val = cur.stop_su;
      ST_STOP_POST: ph_val = cur.start_su;
      default: ph_val = 16'h0000;
    endcase
  end

  i2ctg_timer #(.W(16)) u_phase_tmr (
    .CLK(CLK),
    .SYS_RST(SYS_RST),
    .load(ph_load),
    .value(ph_val),
    .en(1'b1),
    .done(ph_done)
  );

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      state <= ST_IDLE;
      scl_drv <= 1'b0;
      sda_drv <= 1'b0;
      hi_seen <= 1'b0;
      is_stop <= 1'b0;
      tx_bit <= 1'b1;
      RX_BIT <= 1'b0;
      RX_VALID <= 1'b0;
    end else begin
      state <= next_state;
      scl_drv <= next_scl_drv;
      sda_drv <= next_sda_drv;
      hi_seen <= next_hi_seen;
      is_stop <= next_is_stop;
      tx_bit <= next_tx_bit;
      RX_BIT <= next_rx_bit;
      RX_VALID <= next_rx_valid;
    end
  end

  // ==========================================================================
  // Slave data drive: after a falling clock the slave stretches the clock low
  // until its new data bit has met both hold and setup
  i2ctg_slv_e sl_state;
  i2ctg_slv_e next_sl_state;
  logic scl_prev;
  logic sl_scl_drv;
  logic next_sl_scl_drv;
  logic sl_sda_drv;
  logic next_sl_sda_drv;
  logic sl_load;
  logic sl_done;
  logic [15:0] sl_val;

  always_comb begin
    next_sl_state = sl_state;
    next_sl_scl_drv = sl_scl_drv;
    next_sl_sda_drv = SLV_ACTIVE ? sl_sda_drv : 1'b0;
    sl_load = 1'b0;
    sl_val = cur.sda_hd;
    case (sl_state)
      SL_IDLE: begin
        if (SLV_ACTIVE && state == ST_IDLE && scl_prev && !SCL_I) begin
          sl_load = 1'b1;
          next_sl_scl_drv = 1'b1;
          next_sl_state = SL_HOLD;
        end
      end
      SL_HOLD: begin
        if (sl_done) begin
          next_sl_sda_drv = SLV_ACTIVE && !SLV_BIT;
          sl_load = 1'b1;
          sl_val = cur.sda_su;
          next_sl_state = SL_SETUP;
        end
      end
      SL_SETUP: begin
        if (sl_done) begin
          next_sl_scl_drv = 1'b0;
          next_sl_state = SL_IDLE;
        end
      end
      default: begin
        next_sl_state = SL_IDLE;
      end
    endcase
  end

  i2ctg_timer #(.W(16)) u_slave_tmr (
    .CLK(CLK),
    .SYS_RST(SYS_RST),
    .load(sl_load),
    .value(sl_val),
    .en(1'b1),
    .done(sl_done)
  );

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      sl_state <= SL_IDLE;
      scl_prev <= 1'b1;
      sl_scl_drv <= 1'b0;
      sl_sda_drv <= 1'b0;
    end else begin
      sl_state <= next_sl_state;
      scl_prev <= SCL_I;
      sl_scl_drv <= next_sl_scl_drv;
      sl_sda_drv <= next_sl_sda_drv;
    end
  end

  // ==========================================================================
  // Outputs
  assign SCL_O = 1'b0;
  assign SDA_O = 1'b0;
  assign SCL_OE = scl_drv || sl_scl_drv;
  assign SDA_OE = sda_drv || sl_sda_drv;
  assign CMD_READY = (state == ST_IDLE && CMD_OP == OP_START) || (state == ST_HELD && CMD_OP != OP_START);
  assign BUSY = (state != ST_IDLE);
  assign BUS_IDLE = bus_idle;

  // ==========================================================================
  // Checks
  logic [16:0] ph_cyc;
  logic [15:0] us_gap;
  logic us_seen;

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      ph_cyc <= '0;
      us_gap <= '0;
      us_seen <= 1'b0;
    end else begin
      ph_cyc <= (next_state != state) ? 17'h00000 : ph_cyc + {16'h0000, ph_cyc != 17'h1ffff};
      us_gap <= micro_tick ? 16'h0000 : us_gap + 16'h0001;
      us_seen <= us_seen || micro_tick;
    end
  end

  chk_micro_tick_gap: assert property (@(posedge CLK) disable iff (SYS_RST)
    (micro_tick && us_seen && $stable(cur.micro_div)) |-> us_gap == cur.micro_div)
    else $error("micro tick period wrong");
  chk_milli_on_micro: assert property (@(posedge CLK) disable iff (SYS_RST)
    milli_tick |-> micro_tick && ms_cnt >= cur.milli_div)
    else $error("milli tick without micro tick");
  chk_start_setup_len: assert property (@(posedge CLK) disable iff (SYS_RST)
    (state == ST_START_HD && $past(state) == ST_START_SU) |-> $past(ph_cyc) >= {1'b0, $past(cur.start_su)})
    else $error("start setup too short");
  chk_start_hold_len: assert property (@(posedge CLK) disable iff (SYS_RST)
    (state == ST_HELD && $past(state) == ST_START_HD) |-> SCL_OE && $past(ph_cyc) >= {1'b0, $past(cur.start_hd)})
    else $error("start hold too short");
  chk_stop_setup_len: assert property (@(posedge CLK) disable iff (SYS_RST)
    (state == ST_STOP_POST && $past(state) == ST_STOP_SU) |-> $past(ph_cyc) >= {1'b0, $past(cur.stop_su)})
    else $error("stop setup too short");
  chk_stop_hold_len: assert property (@(posedge CLK) disable iff (SYS_RST)
    (state == ST_IDLE && $past(state) == ST_STOP_POST) |-> $past(ph_cyc) >= {1'b0, $past(cur.start_su)})
    else $error("stop hold too short");
  chk_idle_before_start: assert property (@(posedge CLK) disable iff (SYS_RST)
    (state == ST_START_SU && $past(state) == ST_WAIT_IDLE) |-> $past(idle_done && SCL_I && SDA_I))
    else $error("start without idle");
  chk_data_hold_len: assert property (@(posedge CLK) disable iff (SYS_RST)
    (state == ST_BIT_LOW && $past(state) == ST_BIT_HOLD) |-> $past(ph_cyc) >= {1'b0, $past(cur.sda_hd)})
    else $error("data hold too short");
  chk_data_setup_len: assert property (@(posedge CLK) disable iff (SYS_RST)
    (!scl_drv && $past(state) == ST_BIT_LOW) |-> $past(ph_cyc) >= {1'b0, $past(cur.sda_su)})
    else $error("data setup too short");
  chk_shadow_frozen: assert property (@(posedge CLK) disable iff (SYS_RST)
    (BOOT_ACTIVE && $past(BOOT_ACTIVE)) |=> $stable(cur))
    else $error("timing changed during boot");

endmodule

// ---- tb/i2ctg_bus_dev.sv ----
// Far-side bus device model: pull-ups on both lines and clock stretching
module i2ctg_bus_dev (
  // Clock
  input wire logic CLK,
  // Lines pulled low by the design
  input wire logic SCL_OE,
  input wire logic SDA_OE,
  // How long to keep the clock low after each falling edge
  input wire logic [7:0] stretch,
  // Another master pulling the clock low
  input wire logic ext_low,
  // Resolved line levels
  output logic scl,
  output logic sda
);
  logic [7:0] hold = 8'h00;
  logic scl_d = 1'b1;
  // ==========================================================================
  // Open drain: a line nobody pulls reads high through its pull-up
  assign scl = !(SCL_OE || ext_low || hold != 8'h00);
  assign sda = !SDA_OE;
  // Slow device: stretches every low phase of the clock
  always @(posedge CLK) begin
    scl_d <= scl;
    if (scl_d && !scl) begin
      hold <= stretch;
    end else if (hold != 8'h00) begin
      hold <= hold - 8'h01;
    end
  end
endmodule

// ---- tb/tb_i2ctg_top.sv ----
// Self-checking bench for the two-wire bus timing generator
module tb_i2ctg_top;
  timeunit 1ns;
  timeprecision 1ns;
  import i2ctg_pkg::*;
  logic CLK = 1'b0, SYS_RST = 1'b1, REG_WR_EN = 1'b0, REG_RD_EN = 1'b0, BOOT_ACTIVE = 1'b0;
  logic [2:0] REG_ADDR = 3'h0;
  logic [31:0] REG_WDATA = 32'h0, REG_RDATA, d;
  logic CMD_VALID = 1'b0, CMD_BIT = 1'b1, CMD_READY, RX_VALID, RX_BIT, BUSY, BUS_IDLE;
  logic SLV_ACTIVE = 1'b0, SLV_BIT = 1'b0, ext_low = 1'b0;
  logic MICRO_TICK, MILLI_TICK, SCL_O, SCL_OE, SDA_O, SDA_OE, scl, sda;
  i2ctg_op_e CMD_OP = OP_START;
  int err_count = 0, n_tests = 0, n, i;
  int b_r, o_r, s_r, f_r, h_r, l_r, r_r, d_r, su_l, hd_l, ss_l, ph_l, hi_l, lo_l, ds_l, dh_l;
  logic scl_q = 1'b1, sdo_q = 1'b0, sco_q = 1'b0, busy_q = 1'b0;
  logic [31:0] rv [5] = '{32'h03e70063, 32'h019101d7, 32'h00330191, 32'h001f007e, 32'h01f401f4};
  always #25 CLK = !CLK;
  i2ctg_top i2ctg_top_inst (.CLK(CLK), .SYS_RST(SYS_RST), .REG_WR_EN(REG_WR_EN), .REG_RD_EN(REG_RD_EN),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .BOOT_ACTIVE(BOOT_ACTIVE),
    .CMD_VALID(CMD_VALID), .CMD_OP(CMD_OP), .CMD_BIT(CMD_BIT), .CMD_READY(CMD_READY), .RX_VALID(RX_VALID),
    .RX_BIT(RX_BIT), .BUSY(BUSY), .BUS_IDLE(BUS_IDLE), .SLV_ACTIVE(SLV_ACTIVE), .SLV_BIT(SLV_BIT),
    .MICRO_TICK(MICRO_TICK), .MILLI_TICK(MILLI_TICK), .SCL_I(scl), .SCL_O(SCL_O), .SCL_OE(SCL_OE),
    .SDA_I(sda), .SDA_O(SDA_O), .SDA_OE(SDA_OE));
  i2ctg_bus_dev i2ctg_bus_dev_inst (.CLK(CLK), .SCL_OE(SCL_OE), .SDA_OE(SDA_OE), .stretch(8'h1e),
    .ext_low(ext_low), .scl(scl), .sda(sda));
  // ==========================================================================
  // Line monitor: run lengths of each phase, latched where the phase ends
  always @(posedge CLK) begin
    // Counted only once a command is taken, so long idle stretches cannot pass the setup check
    b_r <= (scl && sda && BUSY) ? b_r + 1 : 0;
    o_r <= SDA_OE ? o_r + 1 : 0;
    s_r <= (scl && !sda) ? s_r + 1 : 0;
    f_r <= (!SDA_OE && !SCL_OE) ? f_r + 1 : 0;
    h_r <= scl ? h_r + 1 : 0;
    l_r <= scl ? 0 : l_r + 1;
    r_r <= SDA_OE ? 0 : r_r + 1;
    d_r <= (SCL_OE && SDA_OE) ? d_r + 1 : 0;
    scl_q <= scl;
    sdo_q <= SDA_OE;
    sco_q <= SCL_OE;
    busy_q <= BUSY;
    if (SDA_OE && !sdo_q) su_l <= b_r;
    if (SCL_OE && !sco_q && SDA_OE) hd_l <= o_r;
    if (!SDA_OE && sdo_q) ss_l <= s_r;
    if (!SDA_OE && sdo_q) dh_l <= d_r;
    if (!BUSY && busy_q) ph_l <= f_r;
    if (RX_VALID) hi_l <= h_r;
    if (scl && !scl_q) lo_l <= l_r;
    if (scl && !scl_q) ds_l <= r_r;
  end
  // ==========================================================================
  task end_of_test();
    $display("Checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task chk_eq(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Minimum counts: the design may add a cycle or two of latency per phase
  task chk_ge(input string nm, input int e, input int g);
    n_tests++;
    if (g < e) begin
      err_count++;
      $display("[FAIL] %s expected at least %0d seen %0d", nm, e, g);
    end
  endtask
  function automatic logic sel(input int w);
    case (w)
      0: return MICRO_TICK;
      1: return MILLI_TICK;
      2: return RX_VALID;
      3: return !BUSY;
      4: return CMD_READY;
      5: return SCL_OE;
      6: return SDA_OE;
      default: return !SCL_OE;
    endcase
  endfunction
  task wait_hi(input int w);
    int k;
    for (k = 0; k < 20000; k++) begin
      if (sel(w) === 1'b1) return;
      @(negedge CLK);
    end
    err_count++;
    $display("[FAIL] wait %0d expected 1 seen timeout", w);
    end_of_test();
  endtask
  task cnt_to(input int w, output int c);
    for (c = 0; sel(w) !== 1'b1; c++) begin
      if (c == 100) begin
        err_count++;
        $display("[FAIL] count %0d expected 1 seen timeout", w);
        end_of_test();
      end
      @(negedge CLK);
    end
  endtask
  task gap(input int w, output int c);
    wait_hi(w);
    @(negedge CLK);
    cnt_to(w, c);
    c++;
  endtask
  // One idle edge after each write, so back-to-back writes never re-raise the strobe at once
  task wr(input logic [2:0] a, input logic [31:0] v);
    REG_ADDR = a;
    REG_WDATA = v;
    REG_WR_EN = 1'b1;
    @(negedge CLK);
    REG_WR_EN = 1'b0;
    @(negedge CLK);
  endtask
  task rd(input logic [2:0] a, output logic [31:0] v);
    REG_ADDR = a;
    REG_RD_EN = 1'b1;
    @(negedge CLK);
    REG_RD_EN = 1'b0;
    @(negedge CLK);
    v = REG_RDATA;
  endtask
  // Request held until the edge that sees ready high takes it
  task cmd(input i2ctg_op_e op);
    CMD_OP = op;
    CMD_VALID = 1'b1;
    #1;
    wait_hi(4);
    @(negedge CLK);
    CMD_VALID = 1'b0;
  endtask
  // ==========================================================================
  initial begin
    repeat (5) @(negedge CLK);
    SYS_RST = 1'b0;
    @(negedge CLK);
    chk_eq("bus_idle_early", 32'h0, {31'h0, BUS_IDLE});
    chk_eq("pin_drive_low", 32'h0, {30'h0, SCL_O, SDA_O});
    for (i = 0; i < 5; i++) begin
      rd(i[2:0], d);
      chk_eq("reset_value", rv[i], d);
    end
    rd(3'h7, d);
    chk_eq("unmapped", 32'h0, d);
    wr(3'h0, 32'h00010003);
    repeat (3) @(negedge CLK);
    gap(0, n);
    chk_eq("micro_period", 32'h4, n);
    gap(1, n);
    chk_eq("milli_period", 32'h8, n);
    BOOT_ACTIVE = 1'b1;
    wr(3'h0, 32'h00010007);
    repeat (3) @(negedge CLK);
    gap(0, n);
    chk_eq("micro_in_boot", 32'h4, n);
    BOOT_ACTIVE = 1'b0;
    repeat (3) @(negedge CLK);
    gap(0, n);
    chk_eq("micro_after_boot", 32'h8, n);
    wr(3'h1, 32'h000a0028);
    wr(3'h2, 32'h00020009);
    // Setup count holds margin for the line's rise time, zero in the model
    wr(3'h3, 32'h00030005);
    wr(3'h4, 32'h00100014);
    rd(3'h4, d);
    chk_eq("clock_readback", 32'h00100014, d);
    cmd(OP_START);
    wait_hi(5);
    // Monitor latches land one edge after the event that ends a phase
    @(negedge CLK);
    chk_eq("bus_idle", 32'h1, {31'h0, BUS_IDLE});
    chk_ge("start_setup", 40, su_l);
    chk_ge("start_hold", 10, hd_l);
    rd(3'h5, d);
    chk_eq("status", 32'h3, d);
    cmd(OP_BIT);
    wait_hi(2);
    @(negedge CLK);
    chk_eq("rx_bit", 32'h1, {31'h0, RX_BIT});
    chk_ge("scl_high", 20, hi_l);
    chk_ge("scl_low", 30, lo_l);
    chk_ge("data_setup", 5, ds_l);
    chk_ge("data_hold", 3, dh_l);
    cmd(OP_STOP);
    wait_hi(3);
    @(negedge CLK);
    chk_ge("stop_setup", 9, ss_l);
    chk_ge("stop_hold", 40, ph_l);
    // Idle count zero: the start follows the take after only the setup count
    wr(3'h2, 32'h00000009);
    cmd(OP_START);
    cnt_to(6, n);
    @(negedge CLK);
    chk_eq("idle_zero_start", 32'h1, {31'h0, n < 48});
    chk_ge("start_setup_again", 40, su_l);
    cmd(OP_STOP);
    wait_hi(3);
    // Slave: another master drops the clock, the block answers with a zero bit
    SLV_ACTIVE = 1'b1;
    ext_low = 1'b1;
    @(negedge CLK);
    ext_low = 1'b0;
    wait_hi(5);
    cnt_to(6, n);
    chk_ge("slave_hold", 3, n);
    cnt_to(7, n);
    chk_ge("slave_setup", 5, n);
    chk_eq("slave_data", 32'h1, {31'h0, SDA_OE});
    end_of_test();
  end
endmodule
